// ===== srsr_pkg.sv
// package of constants and types for the reset and soft reset supervisor
package srsr_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned FILT_NS        = 10_000;    // reset filter time, ns
    localparam int unsigned RD_LONG_US     = 10_000;    // extended release delay, us
    localparam int unsigned RD_SHORT_US    = 1_000;     // reduced release delay, us
    localparam int unsigned FILT_CYC       = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RD_LONG_CYC    = RD_LONG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RD_SHORT_CYC   = RD_SHORT_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W          = 20;

    // ****************************************************************
    // mode field encodings
    // ****************************************************************
    localparam logic [1:0] MODE_NORMAL     = 2'h0;
    localparam logic [1:0] MODE_SLEEP      = 2'h1;
    localparam logic [1:0] MODE_STOP       = 2'h2;
    localparam logic [1:0] MODE_SOFT_RST   = 2'h3;

    // ****************************************************************
    // defaults after power-up and the fail count limit
    // ****************************************************************
    localparam logic [1:0] UV_THR_DFLT     = 2'h0;   // lowest falling threshold
    localparam logic [1:0] WDF_MAX         = 2'h2;
    localparam logic [1:0] WDF_CLR         = 2'h0;

    typedef enum logic [3:0] {
        SRSR_INIT     = 4'h1,
        SRSR_NORMAL   = 4'h2,
        SRSR_STOP     = 4'h4,
        SRSR_RESTART  = 4'h8
    } srsr_mode_t;
endpackage

// ===== srsr_top.sv
// reset supervisor with soft reset command handling
`timescale 1ns/100ps
// Behaviour
// - an undervoltage drives reset_out_n low after the filter time and holds it through the delay.
// - after an undervoltage or watchdog reset the release delay is the extended one unless reset_delay_short_sel picks the reduced one.
// - after power-up the output stays low until the regulator is good and the long delay ends.
// - a watchdog trigger failure also asserts the reset output.
// - the undervoltage threshold select is written by software and defaults to the lowest.
// - an accepted soft reset returns to init mode and restores settings to defaults, except a locked pin configuration.
// - with the output-select bit at 0 a soft reset pulses the output with the long delay.
// - with the output-select bit at 1 a soft reset leaves the output high.
// - a soft reset request outside Normal or Stop mode is dropped.
// - a watchdog reset enters Restart and sets failsafe per config unless a soft reset is accepted that cycle, and bumps the fail count up to its limit of 2.
// - a soft reset keeps the pin configuration when its lock bit is set, timer and PWM not.
module srsr_top
    import srsr_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       main_regulator_uv,
    input  wire logic       wd_trigger_fail,
    input  wire logic       watchdog_fail_count_to_failsafe,
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_wr_data,
    input  wire logic       cfg_wr,
    input  wire logic       reset_delay_short_sel_wr,
    input  wire logic       soft_reset_out_sel_wr,
    input  wire logic [1:0] uv_thr_sel_wr,
    input  wire logic [2:0] gpio_cfg_wr,
    input  wire logic       gpio_lock_wr,
    input  wire logic [7:0] timer_pwm_wr,
    output logic            reset_out_n,
    output logic [1:0]      uv_thr_sel,
    output logic            reset_delay_short_sel,
    output logic            soft_reset_out_sel,
    output logic [2:0]      gpio_cfg,
    output logic            gpio_lock,
    output logic [7:0]      timer_pwm,
    output logic [1:0]      watchdog_fail_count,
    output logic            failsafe,
    output logic [3:0]      sbc_mode
);
    // ****************************************************************
    // state
    // ****************************************************************
    srsr_mode_t       mode_ff;
    logic [CNT_W-1:0] filt_ff;
    logic [CNT_W-1:0] dly_ff;
    logic             rst_low_ff;
    logic             long_ff;
    logic             sr_pulse_ff;
    logic             dsel_ff;
    logic             osel_ff;
    logic             lock_ff;
    logic             fs_ff;
    logic [1:0]       uv_thr_ff;
    logic [1:0]       wdf_ff;
    logic [2:0]       gpio_ff;
    logic [7:0]       tp_ff;

    // ****************************************************************
    // decode
    // ****************************************************************
    // normal or stop, the modes that take a soft reset
    function automatic logic is_run(input srsr_mode_t m);
        return (m == SRSR_NORMAL) || (m == SRSR_STOP);
    endfunction

    wire in_run     = is_run(mode_ff);
    wire sr_cmd     = mode_wr && (mode_wr_data == MODE_SOFT_RST);
    wire sr_accept  = sr_cmd && in_run;
    wire sr_src     = sr_pulse_ff;
    wire filt_done  = (filt_ff >= CNT_W'(FILT_CYC));
    wire any_src    = (main_regulator_uv && filt_done) || wd_trigger_fail || sr_src;
    wire [CNT_W-1:0] dly_end = (long_ff || !dsel_ff) ? CNT_W'(RD_LONG_CYC)
                                                     : CNT_W'(RD_SHORT_CYC);
    wire dly_done   = (dly_ff >= dly_end);
    wire wd_evt     = wd_trigger_fail && !rst_low_ff;

    // next values and qualified strobes
    wire [CNT_W-1:0] nxt_filt = filt_ff + CNT_W'(1);
    wire [CNT_W-1:0] nxt_dly  = dly_ff + CNT_W'(1);
    wire [1:0]       nxt_wdf  = wdf_ff + 2'h1;
    wire             wdf_sat  = (wdf_ff == WDF_MAX);          // count saturates
    wire             pin_clr  = sr_accept && !lock_ff;
    wire             pin_wr   = cfg_wr && !sr_accept;

    // ****************************************************************
    // undervoltage filter
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst || !main_regulator_uv)
            filt_ff <= '0;
        else if (!filt_done)
            filt_ff <= nxt_filt;
    end

    // ****************************************************************
    // reset output and release delay
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            rst_low_ff <= 1'b1;
            long_ff    <= 1'b1;
            dly_ff     <= '0;
        end else if (any_src) begin
            rst_low_ff <= 1'b1;
            dly_ff     <= '0;
            long_ff    <= sr_src;
        end else if (rst_low_ff) begin
            if (dly_done)
                rst_low_ff <= 1'b0;
            else
                dly_ff <= nxt_dly;
        end
    end

    // ****************************************************************
    // soft reset pulse request, one cycle
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst)
            sr_pulse_ff <= 1'b0;
        else
            sr_pulse_ff <= sr_accept && !osel_ff;
    end

    // ****************************************************************
    // mode sequencing
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_ff <= SRSR_INIT;
            fs_ff   <= 1'b0;
        end else if (sr_accept) begin
            mode_ff <= SRSR_INIT;
            fs_ff   <= 1'b0;
        end else if (wd_evt) begin
            mode_ff <= SRSR_RESTART;
            fs_ff   <= watchdog_fail_count_to_failsafe;
        end else begin
            case (mode_ff)
                SRSR_INIT, SRSR_NORMAL, SRSR_STOP: begin
                    if (mode_wr && mode_wr_data == MODE_NORMAL)
                        mode_ff <= SRSR_NORMAL;
                    else if (mode_wr && mode_wr_data == MODE_STOP && mode_ff != SRSR_INIT)
                        mode_ff <= SRSR_STOP;
                end
                SRSR_RESTART: begin
                    if (!rst_low_ff && !fs_ff)
                        mode_ff <= SRSR_NORMAL;
                end
                default: mode_ff <= SRSR_INIT;
            endcase
        end
    end

    // ****************************************************************
    // configuration settings
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst || sr_accept) begin
            uv_thr_ff <= UV_THR_DFLT;
            dsel_ff   <= 1'b0;
            osel_ff   <= 1'b0;
            tp_ff     <= '0;
        end else if (cfg_wr) begin
            uv_thr_ff <= uv_thr_sel_wr;
            dsel_ff   <= reset_delay_short_sel_wr;
            osel_ff   <= soft_reset_out_sel_wr;
            tp_ff     <= timer_pwm_wr;
        end
    end

    // ****************************************************************
    // pin configuration, held across soft reset when locked
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst || pin_clr) begin
            gpio_ff <= '0;
            lock_ff <= 1'b0;
        end else if (pin_wr) begin
            lock_ff <= gpio_lock_wr;
            if (!lock_ff)
                gpio_ff <= gpio_cfg_wr;
        end
    end

    // ****************************************************************
    // watchdog failure count, a new failure wins over a clear
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdf_ff <= WDF_CLR;
        end else if (wd_evt) begin
            if (!wdf_sat)
                wdf_ff <= nxt_wdf;
        end else if (sr_accept) begin
            wdf_ff <= WDF_CLR;
        end
    end

    // ****************************************************************
    // limits
    // ****************************************************************
    // power-up release takes the long delay, about ten milliseconds
    // a soft reset always releases on the long delay
    // only a filtered undervoltage or watchdog event can arm the short one
    // watchdog failures while the output is low are not counted again
    // a locked pin setting can only change after the lock is cleared
    // sleep requests are ignored, the block never leaves its clock domain
    // undervoltage compare itself sits outside, only its level comes in

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reset_out_n           = !rst_low_ff;
    assign uv_thr_sel            = uv_thr_ff;
    assign reset_delay_short_sel = dsel_ff;
    assign soft_reset_out_sel    = osel_ff;
    assign gpio_cfg              = gpio_ff;
    assign gpio_lock             = lock_ff;
    assign timer_pwm             = tp_ff;
    assign watchdog_fail_count   = wdf_ff;
    assign failsafe              = fs_ff;
    assign sbc_mode              = mode_ff;
endmodule

// ===== srsr_top_assertions.sv
// port assertions for the reset supervisor
`timescale 1ns/100ps
module srsr_chk
    import srsr_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       main_regulator_uv,
    input wire logic       wd_trigger_fail,
    input wire logic       mode_wr,
    input wire logic [1:0] mode_wr_data,
    input wire logic       cfg_wr,
    input wire logic       reset_delay_short_sel_wr,
    input wire logic       reset_out_n,
    input wire logic       reset_delay_short_sel,
    input wire logic       soft_reset_out_sel,
    input wire logic [2:0] gpio_cfg,
    input wire logic       gpio_lock,
    input wire logic [7:0] timer_pwm,
    input wire logic [3:0] sbc_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // soft reset request, and one that is accepted
    sequence s_soft;
        mode_wr && mode_wr_data == MODE_SOFT_RST;
    endsequence
    sequence s_cfg;
        cfg_wr && !mode_wr;
    endsequence
    property p_dsel;
        s_cfg |=> reset_delay_short_sel == $past(reset_delay_short_sel_wr);
    endproperty
    sequence s_ok;
        s_soft ##0 (sbc_mode == SRSR_NORMAL || sbc_mode == SRSR_STOP);
    endsequence
    a_init_after_rst: assert property ($fell(rst) |-> !reset_out_n && sbc_mode == SRSR_INIT)
        else $error("bad state after reset");
    a_wd_forces_low: assert property (wd_trigger_fail [*2] |-> ##[0:2] !reset_out_n)
        else $error("watchdog fail did not reset");
    a_uv_keeps_low: assert property (main_regulator_uv && !reset_out_n |=> !reset_out_n)
        else $error("reset released during undervoltage");
    a_soft_defaults: assert property (s_ok |=> sbc_mode == SRSR_INIT && timer_pwm == 8'h00)
        else $error("soft reset did not restore");
    a_soft_pulse: assert property (s_ok ##0 !soft_reset_out_sel |-> ##2 !reset_out_n)
        else $error("soft reset did not pulse");
    a_soft_quiet: assert property (s_ok ##0 soft_reset_out_sel && reset_out_n |=> reset_out_n)
        else $error("soft reset pulsed output");
    a_soft_refused: assert property (s_soft ##0 sbc_mode == SRSR_INIT && !cfg_wr
        |=> $stable(timer_pwm)) else $error("refused soft reset had effect");
    a_wd_restart: assert property (wd_trigger_fail && reset_out_n && !mode_wr
        |=> sbc_mode == SRSR_RESTART && !reset_out_n) else $error("watchdog reset not entered");
    a_lock_soft: assert property (gpio_lock ##0 s_ok |=> $stable(gpio_cfg) && gpio_lock)
        else $error("locked pin config lost");
    a_delay_sel: assert property (p_dsel)
        else $error("delay select not loaded");
endmodule
bind srsr_top srsr_chk u_chk (.*);

// ===== srsr_mcu.sv
// microcontroller model issuing mode commands
`timescale 1ns/100ps
module srsr_mcu
(
    input wire logic       mclk,
    input wire logic       go,
    input wire logic [1:0] cmd,
    output logic           mode_wr,
    output logic [1:0]     mode_wr_data
);
    initial {mode_wr, mode_wr_data} = 3'h0;
    // one-cycle write strobe, 11 asks for soft reset; idle data inverts
    always @(posedge mclk) begin
        mode_wr <= go;
        mode_wr_data <= go ? cmd : ~mode_wr_data;
    end
endmodule

// ===== srsr_top_tb.sv
// self-checking bench for the reset supervisor
`timescale 1ns/100ps
module srsr_top_tb
    import srsr_pkg::*;
;
    logic mclk, rst, main_regulator_uv, wd_trigger_fail, watchdog_fail_count_to_failsafe, cfg_wr, go;
    logic reset_delay_short_sel_wr, soft_reset_out_sel_wr, gpio_lock_wr;
    logic [1:0] uv_thr_sel_wr, cmd;
    logic [2:0] gpio_cfg_wr;
    logic [7:0] timer_pwm_wr;
    logic [15:0] wv, v, e;
    wire logic mode_wr, reset_out_n, reset_delay_short_sel, soft_reset_out_sel, gpio_lock, failsafe;
    wire logic [1:0] mode_wr_data, uv_thr_sel, watchdog_fail_count;
    wire logic [2:0] gpio_cfg;
    wire logic [7:0] timer_pwm;
    wire logic [3:0] sbc_mode;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    assign {reset_delay_short_sel_wr, soft_reset_out_sel_wr, uv_thr_sel_wr, gpio_cfg_wr,
        gpio_lock_wr, timer_pwm_wr} = wv;
    wire logic [15:0] rb = {reset_delay_short_sel, soft_reset_out_sel, uv_thr_sel, gpio_cfg,
        gpio_lock, timer_pwm};
    srsr_top DUT (.*);
    srsr_mcu u_mcu (.mclk(mclk), .go(go), .cmd(cmd), .mode_wr(mode_wr), .mode_wr_data(mode_wr_data));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // settings expected after a soft reset
    function automatic logic [15:0] soft_exp(input logic [15:0] s);
        return {2'h0, UV_THR_DFLT, s[8] ? s[11:9] : 3'h0, s[8], 8'h00};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [15:0] d);
        @(posedge mclk);
        wv <= d;
        cfg_wr <= 1'b1;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic mode(input logic [1:0] m);
        @(posedge mclk);
        go <= 1'b1;
        cmd <= m;
        @(posedge mclk);
        go <= 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // cycle ceiling against a hang
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 45000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        {rst, main_regulator_uv, wd_trigger_fail, watchdog_fail_count_to_failsafe, cfg_wr, go} = 6'h01 << 5;
        {wv, cmd} = '0;
        void'($urandom(74434));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({reset_out_n, sbc_mode}, {1'b0, SRSR_INIT});
        chk(rb, 16'h0000);
        // soft reset from normal and from stop, random settings
        for (int k = 0; k < 4; k++) begin
            mode(MODE_NORMAL);
            mode(k[0] ? MODE_STOP : MODE_SLEEP);
            chk(sbc_mode, k[0] ? SRSR_STOP : SRSR_NORMAL);
            v = 16'($urandom) & 16'hFEFF;
            cfg(v);
            chk(rb, v);
            mode(MODE_SOFT_RST);
            chk({reset_out_n, sbc_mode}, {1'b0, SRSR_INIT});
            chk(rb, soft_exp(v));
        end
        // lock, locked write, refused and accepted soft reset
        cfg(v | 16'h0100);
        e = v | 16'h0100;
        cfg(e ^ 16'h0E00);
        chk(rb, e);
        mode(MODE_SOFT_RST);
        chk(rb, e);
        mode(MODE_NORMAL);
        mode(MODE_SOFT_RST);
        chk(rb, soft_exp(e));
        // short delay armed, undervoltage restarts the release count
        cfg(16'hC000);
        @(posedge mclk);
        main_regulator_uv <= 1'b1;
        repeat (450) @(negedge mclk);
        chk(reset_out_n, 1'b0);
        @(posedge mclk);
        main_regulator_uv <= 1'b0;
        repeat (RD_SHORT_CYC - 10) @(negedge mclk);
        chk(reset_out_n, 1'b0);
        repeat (20) @(negedge mclk);
        chk(reset_out_n, 1'b1);
        // undervoltage shorter than the filter time is ignored
        @(posedge mclk);
        main_regulator_uv <= 1'b1;
        repeat (300) @(negedge mclk);
        chk(reset_out_n, 1'b1);
        @(posedge mclk);
        main_regulator_uv <= 1'b0;
        // quiet soft reset, then watchdog fail into fail-safe
        mode(MODE_NORMAL);
        mode(MODE_SOFT_RST);
        chk({reset_out_n, sbc_mode}, {1'b1, SRSR_INIT});
        mode(MODE_NORMAL);
        @(posedge mclk);
        watchdog_fail_count_to_failsafe <= 1'b1;
        wd_trigger_fail <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(reset_out_n, 1'b0);
        chk({failsafe, watchdog_fail_count, sbc_mode}, {1'b1, 2'h1, SRSR_RESTART});
        @(posedge mclk);
        wd_trigger_fail <= 1'b0;
        mode(MODE_SOFT_RST);
        chk(sbc_mode, SRSR_RESTART);
        final_report();
    end
endmodule
